// ---- src/crr_pkg.sv ----
// Summary of operation
// (RULE1) amplitude results are valid only after software reads diagnostic done as 1
// (RULE2) reserved bits 15 and 7 of amplitude regs, 1:0 of general read zero
// (RULE3) amplitude register four bits 14:8 hold receive-pair peak three amplitude
// (RULE4) amplitude register four bits 6:0 hold receive-pair peak two amplitude
// (RULE5) amplitude register five bits 14:8 hold receive-pair peak five amplitude
// (RULE6) amplitude register five bits 6:0 hold receive-pair peak four amplitude
// (RULE7) general bits 15:11 give transmit-pair peak polarities five down to one
// (RULE8) general bits 10:6 give receive-pair peak polarities five down to one
// (RULE9) general bit 5 flags cross reflection on the transmit pair
// (RULE10) general bit 4 flags cross reflection on the receive pair
// (RULE11) general bit 3 flags more than five transmit-pair reflections
// (RULE12) general bit 2 flags more than five receive-pair reflections
// (RULE13) software combines general results with location and amplitude results
// (RULE14) reads have no side effects; software writes to results are ignored
`default_nettype none
package crr_pkg;
   // ----------------------------------------
   // register map (index = printed offset)
   // ----------------------------------------
   localparam logic [9:0] IDX_DIAG_CONTROL = 10'h01e;
   localparam logic [9:0] IDX_AMP_2_3 = 10'h183;
   localparam logic [9:0] IDX_AMP_4_5 = 10'h184;
   localparam logic [9:0] IDX_GENERAL = 10'h18a;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h190;
   localparam logic [9:0] IDX_IRQ_ENABLE = 10'h191;
   localparam logic [9:0] IDX_IRQ_CLEAR = 10'h192;
   // ----------------------------------------
   // field layout
   // ----------------------------------------
   localparam int AMP_W = 7;
   localparam int AMP_HI_LSB = 8;
   localparam int AMP_LO_LSB = 0;
   localparam int POL_TX_LSB = 11;
   localparam int POL_RX_LSB = 6;
   localparam int BIT_CROSS_TX = 5;
   localparam int BIT_CROSS_RX = 4;
   localparam int BIT_OVER_TX = 3;
   localparam int BIT_OVER_RX = 2;
   localparam int BIT_DONE = 1;
   localparam int NUM_EVT = 3;
   localparam int EVT_DONE = 0;
   localparam int EVT_CROSS = 1;
   localparam int EVT_OVER = 2;
   localparam logic [15:0] RESET_VAL = 16'h0000;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   // ----------------------------------------
   // result carried from the engine
   // ----------------------------------------
   typedef struct packed {
      logic [4:0] pol_tx;
      logic [4:0] pol_rx;
      logic cross_tx;
      logic cross_rx;
      logic over_tx;
      logic over_rx;
      logic [AMP_W-1:0] amp_rx2;
      logic [AMP_W-1:0] amp_rx3;
      logic [AMP_W-1:0] amp_rx4;
      logic [AMP_W-1:0] amp_rx5;
   } crr_result_t;
endpackage
`default_nettype wire

// ---- src/crr_store.sv ----
`default_nettype none
module crr_store
   import crr_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // engine side
   input wire logic load,
   input var crr_result_t res_in,
   // held result
   output var crr_result_t res_q
);
   // ----------------------------------------
   // result storage, only the engine writes it
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_q <= '0;
      end else if (load) begin
         res_q <= res_in; // RULE14
      end
   end

   property p_store_load;
      @(posedge pclk) disable iff (!presetn) load |=> res_q == $past(res_in);
   endproperty
   a_store_load: assert property (p_store_load) else $error("result not loaded"); // RULE14

   property p_store_hold;
      @(posedge pclk) disable iff (!presetn) !load |=> $stable(res_q);
   endproperty
   a_store_hold: assert property (p_store_hold) else $error("result changed without load"); // RULE14
endmodule
`default_nettype wire

// ---- src/crr_regs.sv ----
`default_nettype none
module crr_regs
   import crr_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // engine
   input wire logic test_done,
   input var crr_result_t test_result,
   // interrupt
   output logic irq
);
   crr_result_t res_q;
   logic done_q;
   logic [NUM_EVT-1:0] sts_q;
   logic [NUM_EVT-1:0] en_q;
   logic [NUM_EVT-1:0] evt;
   logic [15:0] rdata_d;
   logic hit;
   logic [9:0] idx;
   logic setup;
   logic wr_clr;

   crr_store u_store (
      .pclk(pclk),
      .presetn(presetn),
      .load(test_done),
      .res_in(test_result),
      .res_q(res_q)
   );

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   assign idx = paddr[11:2];
   assign setup = psel && !penable;
   assign wr_clr = psel && penable && pready && pwrite && idx == IDX_IRQ_CLEAR;

   always_comb begin
      hit = 1'b1;
      rdata_d = 16'h0000;
      unique case (idx)
         IDX_DIAG_CONTROL: rdata_d[BIT_DONE] = done_q; // RULE1
         IDX_AMP_2_3: begin
            rdata_d[AMP_HI_LSB +: AMP_W] = res_q.amp_rx3; // RULE3
            rdata_d[AMP_LO_LSB +: AMP_W] = res_q.amp_rx2; // RULE4
         end
         IDX_AMP_4_5: begin
            rdata_d[AMP_HI_LSB +: AMP_W] = res_q.amp_rx5; // RULE5
            rdata_d[AMP_LO_LSB +: AMP_W] = res_q.amp_rx4; // RULE6
         end
         IDX_GENERAL: begin
            rdata_d[POL_TX_LSB +: 5] = res_q.pol_tx; // RULE7
            rdata_d[POL_RX_LSB +: 5] = res_q.pol_rx; // RULE8
            rdata_d[BIT_CROSS_TX] = res_q.cross_tx; // RULE9
            rdata_d[BIT_CROSS_RX] = res_q.cross_rx; // RULE10
            rdata_d[BIT_OVER_TX] = res_q.over_tx; // RULE11
            rdata_d[BIT_OVER_RX] = res_q.over_rx; // RULE12
         end
         IDX_IRQ_STATUS: rdata_d[NUM_EVT-1:0] = sts_q;
         IDX_IRQ_ENABLE: rdata_d[NUM_EVT-1:0] = en_q;
         IDX_IRQ_CLEAR: rdata_d = 16'h0000;
         default: hit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // no wait state: answer in the cycle after setup
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (setup) begin
         pready <= 1'b1;
         pslverr <= !hit;
         prdata <= (hit && !pwrite) ? {16'h0000, rdata_d} : 32'h00000000; // RULE2
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // writes reach only the enable and clear registers; results ignore them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= '0;
      end else if (psel && penable && pready && pwrite && idx == IDX_IRQ_ENABLE) begin
         en_q <= pwdata[NUM_EVT-1:0];
      end
   end

   // ----------------------------------------
   // diagnostic done, set by engine, sticky until reset
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
      end else if (test_done) begin
         done_q <= 1'b1; // RULE1
      end
   end

   // ----------------------------------------
   // interrupts: set wins over clear
   // ----------------------------------------
   always_comb begin
      evt = '0;
      evt[EVT_DONE] = test_done;
      evt[EVT_CROSS] = test_done && (test_result.cross_tx || test_result.cross_rx);
      evt[EVT_OVER] = test_done && (test_result.over_tx || test_result.over_rx);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= '0;
      end else begin
         sts_q <= (sts_q & ~(wr_clr ? pwdata[NUM_EVT-1:0] : '0)) | evt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((sts_q & ~(wr_clr ? pwdata[NUM_EVT-1:0] : '0)) | evt) & en_q);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_ready_one;
      @(posedge pclk) disable iff (!presetn) setup |=> pready ##1 !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("pready timing wrong"); // RULE14

   property p_amp_rsvd;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && (idx == IDX_AMP_2_3 || idx == IDX_AMP_4_5)) |=>
         (prdata[15] == 1'b0 && prdata[7] == 1'b0);
   endproperty
   a_amp_rsvd: assert property (p_amp_rsvd) else $error("amplitude reserved bit set"); // RULE2

   property p_gen_rsvd;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && idx == IDX_GENERAL) |=> prdata[1:0] == 2'b00;
   endproperty
   a_gen_rsvd: assert property (p_gen_rsvd) else $error("general reserved bits set"); // RULE2

   property p_amp23;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && idx == IDX_AMP_2_3 && !test_done) |=>
         (prdata[14:8] == res_q.amp_rx3 && prdata[6:0] == res_q.amp_rx2);
   endproperty
   a_amp23: assert property (p_amp23) else $error("amplitude 2/3 wrong"); // RULE3

   property p_amp45;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && idx == IDX_AMP_4_5 && !test_done) |=>
         (prdata[14:8] == res_q.amp_rx5 && prdata[6:0] == res_q.amp_rx4);
   endproperty
   a_amp45: assert property (p_amp45) else $error("amplitude 4/5 wrong"); // RULE5

   property p_pol;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && idx == IDX_GENERAL && !test_done) |=>
         (prdata[15:11] == res_q.pol_tx && prdata[10:6] == res_q.pol_rx);
   endproperty
   a_pol: assert property (p_pol) else $error("polarity fields wrong"); // RULE7

   property p_flags;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && idx == IDX_GENERAL && !test_done) |=>
         (prdata[5:2] == {res_q.cross_tx, res_q.cross_rx, res_q.over_tx, res_q.over_rx});
   endproperty
   a_flags: assert property (p_flags) else $error("cross or overflow flags wrong"); // RULE9

   property p_done;
      @(posedge pclk) disable iff (!presetn) test_done |=> done_q && sts_q[EVT_DONE];
   endproperty
   a_done: assert property (p_done) else $error("done not flagged"); // RULE1

   property p_irq;
      @(posedge pclk) disable iff (!presetn) (|(sts_q & en_q)) && !wr_clr |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq low while enabled status set");

   property p_irq_low;
      @(posedge pclk) disable iff (!presetn) !(|(sts_q & en_q)) && !test_done |=> !irq;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq high with no enabled status");

   property p_unmapped;
      @(posedge pclk) disable iff (!presetn) (setup && !hit) |=> pslverr && prdata == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

   c_done: cover property (@(posedge pclk) disable iff (!presetn) test_done);
   c_read_gen: cover property (@(posedge pclk) disable iff (!presetn) setup && !pwrite && idx == IDX_GENERAL);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
   c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb
   import crr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, test_done, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [63:0] rnd;
   crr_result_t test_result, r;
   crr_result_t hist[$];
   logic [2:0] m_stat, m_en;
   logic m_done;
   int errors, total_checks, cycles;
   logic [9:0] idxs[6] = '{IDX_DIAG_CONTROL, IDX_AMP_2_3, IDX_AMP_4_5, IDX_GENERAL, IDX_IRQ_STATUS, IDX_IRQ_ENABLE};

   crr_regs crr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .test_done(test_done), .test_result(test_result), .irq(irq));

   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end

   // ----------------------------------------
   // model and shared tasks
   // ----------------------------------------
   function automatic logic [15:0] exp_of(input logic [9:0] idx);
      crr_result_t h;
      h = (hist.size() > 0) ? hist[$] : crr_result_t'(0);
      case (idx)
         IDX_DIAG_CONTROL: return {14'h0000, m_done, 1'h0};
         IDX_AMP_2_3: return {1'h0, h.amp_rx3, 1'h0, h.amp_rx2};
         IDX_AMP_4_5: return {1'h0, h.amp_rx5, 1'h0, h.amp_rx4};
         IDX_GENERAL: return {h.pol_tx, h.pol_rx, h.cross_tx, h.cross_rx, h.over_tx, h.over_rx, 2'h0};
         IDX_IRQ_STATUS: return {13'h0000, m_stat};
         IDX_IRQ_ENABLE: return {13'h0000, m_en};
         default: return 16'h0000;
      endcase
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic read_all();
      foreach (idxs[i]) begin
         apb(1'h0, idxs[i], 32'h0000_0000);
         check("register", rd, {16'h0000, exp_of(idxs[i])});
         check("pslverr", {31'h0, err}, 32'h0000_0000);
      end
   endtask

   task automatic fire(input crr_result_t v);
      test_result <= v;
      test_done <= 1'h1;
      @(posedge pclk);
      test_done <= 1'h0;
      hist.push_back(v);
      m_done = 1'h1;
      m_stat = m_stat | {v.over_tx | v.over_rx, v.cross_tx | v.cross_rx, 1'h1};
      @(posedge pclk);
   endtask

   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge pclk);
      check("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, test_done, m_done} = 6'h00;
      {paddr, pwdata, test_result, m_stat, m_en} = '0;
      {errors, total_checks, cycles} = '0;
      rnd = {32'h0, $urandom(14547)};
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      read_all();
      apb(1'h0, 10'h3ff, 32'h0000_0000);
      check("unmapped data", rd, 32'h0000_0000);
      check("unmapped err", {31'h0, err}, 32'h0000_0001);
      for (int i = 0; i < 8; i++) begin
         rnd = {$urandom, $urandom};
         r = (i == 0) ? '1 : crr_result_t'(rnd[$bits(crr_result_t)-1:0]);
         fire(r);
         read_all();
         for (int k = 0; k < 5; k++) begin
            apb(1'h1, idxs[k], $urandom);
         end
         read_all();
      end
      // interrupt: mask, clear, enable
      apb(1'h1, IDX_IRQ_ENABLE, 32'h0000_0000);
      irq_chk(1'h0);
      apb(1'h1, IDX_IRQ_CLEAR, 32'h0000_0007);
      m_stat = 3'h0;
      r = '0;
      r.cross_rx = 1'h1;
      fire(r);
      apb(1'h1, IDX_IRQ_ENABLE, 32'h0000_0002);
      m_en = 3'h2;
      irq_chk(1'h1);
      apb(1'h1, IDX_IRQ_ENABLE, 32'h0000_0004);
      m_en = 3'h4;
      irq_chk(1'h0);
      apb(1'h1, IDX_IRQ_ENABLE, 32'h0000_0003);
      m_en = 3'h3;
      irq_chk(1'h1);
      apb(1'h1, IDX_IRQ_CLEAR, 32'h0000_0003);
      m_stat = 3'h0;
      irq_chk(1'h0);
      read_all();
      // mid-run reset: every result, flag and interrupt returns to zero
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      hist.delete();
      {m_done, m_stat, m_en} = '0;
      check("irq after reset", {31'h0, irq}, 32'h0000_0000);
      read_all();
      give_verdict();
   end
endmodule
`default_nettype wire
